/* File: hdl/twoc_top.sv */
// timer waveform output unit: compare/capture, pwm and delayed pulse
`include "twoc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module twoc_top
   import twoc_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // count clock enable pulse
   input wire logic count_tick,
   // settings
   input wire twoc_cfg_t cfg,
   input wire twoc_ch_cfg_t ch_cfg [4],
   // general register write port
   input wire logic gr_wr_en,
   input wire logic [1:0] gr_wr_sel,
   input wire logic [CNT_W-1:0] gr_wr_data,
   // port fallback drive, per pin
   input wire logic [3:0] port_out,
   input wire logic [3:0] port_oe,
   // external pins, index 0..3 = timer_pin_a..d
   input wire logic [3:0] timer_pin_in,
   output logic [3:0] timer_pin_out,
   output logic [3:0] timer_pin_oe,
   input wire logic pulse_trigger_in,
   // state
   output logic [CNT_W-1:0] main_counter,
   output logic [CNT_W-1:0] general_reg [4]
);

   // refused at elaboration: the compare and increment logic assume this range
   if (CNT_W < 2 || CNT_W > 32)
   begin : g_bad_width
      $error("twoc_top: CNT_W must be 2..32");
   end

   // ----------------------------------------------------------------
   // pin function decode
   // ----------------------------------------------------------------
   function automatic twoc_fn_t pin_fn(input int idx, input twoc_cfg_t c, input twoc_ch_cfg_t h);
      logic dp;
      logic cap;
      logic cmp;
      dp = (c.delay_pulse_mode_sel == `TWOC_DP_ACTIVE);
      cap = h.io_ctrl[`TWOC_IO_CAP_BIT];
      cmp = !cap && (h.io_ctrl[1:0] != 2'b00) && !h.out_disable;
      pin_fn = TWOC_FN_PORT;
      if (idx == `TWOC_CH_A)
      begin
         if (cap)
            pin_fn = TWOC_FN_CAP;
         else if (cmp)
            pin_fn = TWOC_FN_CMP;
      end
      else if (idx == `TWOC_CH_B && dp)
      begin
         if (!h.out_disable)
            pin_fn = TWOC_FN_PULSE;
      end
      else if (!dp && h.duty_mode_sel)
      begin
         if (!h.out_disable)
            pin_fn = TWOC_FN_PWM;
      end
      else if (cap)
         pin_fn = TWOC_FN_CAP;
      else if (cmp)
         pin_fn = TWOC_FN_CMP;
      // anything else stays a port
   endfunction : pin_fn

   twoc_fn_t fn_now [4];
   twoc_fn_t fn_ff [4];

   // ----------------------------------------------------------------
   // pin and trigger synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pin_s1_ff;
   logic [3:0] pin_s2_ff;
   logic [3:0] pin_d_ff;
   logic trig_s1_ff;
   logic trig_s2_ff;
   logic trig_d_ff;
   logic trig_evt;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // rest at the pulled-up idle level, so release makes no false edge
         pin_s1_ff <= 4'hf;
         pin_s2_ff <= 4'hf;
         pin_d_ff <= 4'hf;
         trig_s1_ff <= 1'b1;
         trig_s2_ff <= 1'b1;
         trig_d_ff <= 1'b1;
      end
      else
      begin
         pin_s1_ff <= timer_pin_in;
         pin_s2_ff <= pin_s1_ff;
         pin_d_ff <= pin_s2_ff;
         trig_s1_ff <= pulse_trigger_in;
         trig_s2_ff <= trig_s1_ff;
         trig_d_ff <= trig_s2_ff;
      end
   end

   always_comb
   begin
      case (cfg.trigger_edge_sel)
         `TWOC_EDGE_RISE: trig_evt = trig_s2_ff && !trig_d_ff;
         `TWOC_EDGE_FALL: trig_evt = !trig_s2_ff && trig_d_ff;
         `TWOC_EDGE_BOTH: trig_evt = trig_s2_ff ^ trig_d_ff;
         default: trig_evt = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // compare match and trigger acceptance
   // ----------------------------------------------------------------
   logic [3:0] match;
   logic [3:0] cap_evt;
   logic dp_mode;
   logic trig_ok;
   logic halted_ff;

   assign dp_mode = (cfg.delay_pulse_mode_sel == `TWOC_DP_ACTIVE);
   // accepted only while pin b rests at its initial level
   assign trig_ok = dp_mode && trig_evt &&
                    (timer_pin_out[1] == ch_cfg[1].initial_level);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_dec
         assign fn_now[gi] = pin_fn(gi, cfg, ch_cfg[gi]);
         assign match[gi] = count_tick && (main_counter == general_reg[gi]);
         assign cap_evt[gi] = (fn_now[gi] == TWOC_FN_CAP) && pin_s2_ff[gi] && !pin_d_ff[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         halted_ff <= 1'b0;
      else if (!cfg.count_start)
         halted_ff <= 1'b0;
      else if (match[0] && cfg.stop_on_match_a)
         halted_ff <= 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         main_counter <= CNT_W'(`TWOC_CNT_RST);
      else if (trig_ok)
         main_counter <= '0;
      else if (cfg.clear_on_match_a && (match[0] || cap_evt[0]))
         main_counter <= '0;
      else if (count_tick && cfg.count_start && !halted_ff && !(match[0] && cfg.stop_on_match_a))
         main_counter <= main_counter + 1'b1;
   end

   // ----------------------------------------------------------------
   // general registers: capture, buffer copy, then software write
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_gr
         logic copy;
         assign copy = (gi == `TWOC_CH_B) && dp_mode && cfg.buffer_mode_b &&
                       (match[0] || trig_ok);
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               general_reg[gi] <= CNT_W'(`TWOC_CNT_RST);
            else if (cap_evt[gi])
               general_reg[gi] <= main_counter;
            else if (copy)
               general_reg[gi] <= general_reg[3];
            else if (gr_wr_en && gr_wr_sel == 2'(gi))
               general_reg[gi] <= gr_wr_data;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // pin levels
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_pin
         logic entering;
         logic dmatch;
         assign entering = (fn_now[gi] != fn_ff[gi]);
         // equal duty and period freezes the output
         assign dmatch = (general_reg[gi] != general_reg[0]);

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               fn_ff[gi] <= TWOC_FN_PORT;
            else
               fn_ff[gi] <= fn_now[gi];
         end

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               timer_pin_out[gi] <= `TWOC_PIN_RST;
               timer_pin_oe[gi] <= 1'b0;
            end
            else
            begin
               timer_pin_oe[gi] <= (fn_now[gi] == TWOC_FN_CMP) || (fn_now[gi] == TWOC_FN_PWM) ||
                                   (fn_now[gi] == TWOC_FN_PULSE) ||
                                   ((fn_now[gi] == TWOC_FN_PORT) && port_oe[gi]);
               case (fn_now[gi])
                  TWOC_FN_PWM:
                  begin
                     if (entering)
                        timer_pin_out[gi] <= (ch_cfg[gi].initial_level == ch_cfg[gi].active_level);
                     else if (match[gi] && dmatch)
                        timer_pin_out[gi] <= ch_cfg[gi].active_level;
                     else if (match[0] && dmatch)
                        timer_pin_out[gi] <= !ch_cfg[gi].active_level;
                  end
                  TWOC_FN_PULSE:
                  begin
                     if (entering || match[0])
                        timer_pin_out[gi] <= ch_cfg[gi].initial_level;
                     else if (match[gi])
                        timer_pin_out[gi] <= !ch_cfg[gi].initial_level;
                  end
                  TWOC_FN_CMP:
                  begin
                     if (match[gi])
                     begin
                        case (ch_cfg[gi].io_ctrl[1:0])
                           `TWOC_CMP_LOW: timer_pin_out[gi] <= 1'b0;
                           `TWOC_CMP_HIGH: timer_pin_out[gi] <= 1'b1;
                           `TWOC_CMP_TOGGLE: timer_pin_out[gi] <= !timer_pin_out[gi];
                           default: timer_pin_out[gi] <= timer_pin_out[gi];
                        endcase
                     end
                  end
                  TWOC_FN_PORT:
                     timer_pin_out[gi] <= port_out[gi];
                  default:
                     timer_pin_out[gi] <= port_out[gi];
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_clear_a;
      match[0] && cfg.clear_on_match_a;
   endsequence

   sequence s_trig_accept;
      trig_ok && cfg.buffer_mode_b && !cap_evt[1];
   endsequence

   a_match_exact: assert property (@(posedge clk) disable iff (!rst_n)
      match[1] |-> count_tick && main_counter == general_reg[1])
      else $error("match b without equal count");
   a_match_once: assert property (@(posedge clk) disable iff (!rst_n)
      (match[2] && cfg.count_start && !halted_ff && !cfg.stop_on_match_a && !cfg.clear_on_match_a
       && !trig_ok && !gr_wr_en && !cap_evt[2]) |=> !match[2])
      else $error("match c held past one count");
   a_clear_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_clear_a |=> main_counter == '0)
      else $error("counter not cleared on match a");
   a_count_on: assert property (@(posedge clk) disable iff (!rst_n)
      (match[0] && !cfg.clear_on_match_a && !cfg.stop_on_match_a && cfg.count_start
       && !halted_ff && !trig_ok) |=> main_counter == $past(main_counter) + 1'b1)
      else $error("counter stopped after match a");
   a_pwm_duty: assert property (@(posedge clk) disable iff (!rst_n)
      (fn_now[2] == TWOC_FN_PWM && fn_ff[2] == TWOC_FN_PWM && match[2]
       && general_reg[2] != general_reg[0]) |=> timer_pin_out[2] == $past(ch_cfg[2].active_level))
      else $error("pwm c level wrong on duty match");
   a_pwm_equal: assert property (@(posedge clk) disable iff (!rst_n)
      (fn_now[3] == TWOC_FN_PWM && fn_ff[3] == TWOC_FN_PWM
       && general_reg[3] == general_reg[0]) |=> $stable(timer_pin_out[3]))
      else $error("pwm d changed with equal duty");
   a_pwm_init: assert property (@(posedge clk) disable iff (!rst_n)
      (fn_now[1] == TWOC_FN_PWM && fn_ff[1] != TWOC_FN_PWM)
      |=> timer_pin_out[1] == ($past(ch_cfg[1].initial_level) == $past(ch_cfg[1].active_level)))
      else $error("pwm b initial level wrong");
   a_pulse_edge: assert property (@(posedge clk) disable iff (!rst_n)
      (fn_now[1] == TWOC_FN_PULSE && fn_ff[1] == TWOC_FN_PULSE && match[1] && !match[0])
      |=> timer_pin_out[1] != $past(ch_cfg[1].initial_level))
      else $error("pulse b not started on match b");
   a_trig_copy: assert property (@(posedge clk) disable iff (!rst_n)
      s_trig_accept |=> general_reg[1] == $past(general_reg[3]) && main_counter == '0)
      else $error("accepted trigger did not copy and restart");
   a_trig_ignore: assert property (@(posedge clk) disable iff (!rst_n)
      (dp_mode && trig_evt && timer_pin_out[1] != ch_cfg[1].initial_level && !match[0]
       && !gr_wr_en) |=> $stable(general_reg[1]))
      else $error("ignored trigger copied buffer");
   a_pulse_pin: assert property (@(posedge clk) disable iff (!rst_n)
      (dp_mode && !ch_cfg[1].out_disable) |=> timer_pin_oe[1])
      else $error("pin b not driven in pulse mode");
   a_trig_single: assert property (@(posedge clk) disable iff (!rst_n)
      trig_evt |=> !trig_evt)
      else $error("one edge gave two events");

endmodule : twoc_top
`default_nettype wire

/* File: shared/twoc_defines.svh */
// constants for the timer waveform output unit
`ifndef TWOC_DEFINES_SVH
`define TWOC_DEFINES_SVH
// io control field: top bit selects input capture
`define TWOC_IO_CAP_BIT 2
// compare output action in the low field bits
`define TWOC_CMP_LOW 2'b01
`define TWOC_CMP_HIGH 2'b10
`define TWOC_CMP_TOGGLE 2'b11
// trigger edge select codes
`define TWOC_EDGE_OFF 2'b00
`define TWOC_EDGE_RISE 2'b01
`define TWOC_EDGE_FALL 2'b10
`define TWOC_EDGE_BOTH 2'b11
// delayed-pulse mode is entered when the select bit is at this value
`define TWOC_DP_ACTIVE 1'b0
// channel indices
`define TWOC_CH_A 0
`define TWOC_CH_B 1
// reset values
`define TWOC_CNT_RST 16'h0000
`define TWOC_PIN_RST 1'b0
`endif

/* File: shared/twoc_pkg.sv */
// types shared by the timer waveform output unit
package twoc_pkg;
   // one-hot pin function
   typedef enum logic [4:0] {
      TWOC_FN_PORT  = 5'b0_0001,
      TWOC_FN_CMP   = 5'b0_0010,
      TWOC_FN_CAP   = 5'b0_0100,
      TWOC_FN_PWM   = 5'b0_1000,
      TWOC_FN_PULSE = 5'b1_0000
   } twoc_fn_t;

   // per-channel settings
   typedef struct packed {
      logic [2:0] io_ctrl;
      logic out_disable;
      logic duty_mode_sel;
      logic initial_level;
      logic active_level;
   } twoc_ch_cfg_t;

   // unit-wide settings
   typedef struct packed {
      logic delay_pulse_mode_sel;
      logic [1:0] trigger_edge_sel;
      logic stop_on_match_a;
      logic clear_on_match_a;
      logic buffer_mode_b;
      logic count_start;
   } twoc_cfg_t;
endpackage : twoc_pkg

/* File: verif/tb.sv */
// self-checking bench for the timer waveform output unit
`timescale 1ns/100ps
`default_nettype none
module tb
   import twoc_pkg::*;
;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic count_tick, gr_wr_en, trig_fire, trig_n;
   twoc_cfg_t cfg;
   twoc_ch_cfg_t ch_cfg [4];
   logic [1:0] gr_wr_sel;
   logic [15:0] gr_wr_data, main_counter, per, duty [4];
   logic [15:0] general_reg [4];
   logic [3:0] port_out, port_oe, ext_val, ext_en, pin_lvl, timer_pin_out, timer_pin_oe;
   int error_cnt = 0;
   int checked = 0;
   int seed = 32'h12fe;
   int ones [4];
   always #4 clk = ~clk;

   twoc_top #(.CNT_W(16)) uut (.clk(clk), .rst_n(rst_n), .count_tick(count_tick), .cfg(cfg), .ch_cfg(ch_cfg),
      .gr_wr_en(gr_wr_en), .gr_wr_sel(gr_wr_sel), .gr_wr_data(gr_wr_data), .port_out(port_out),
      .port_oe(port_oe), .timer_pin_in(pin_lvl), .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
      .pulse_trigger_in(trig_n), .main_counter(main_counter), .general_reg(general_reg));
   twoc_ext_model ext (.clk(clk), .pin_out(timer_pin_out), .pin_oe(timer_pin_oe), .ext_val(ext_val),
      .ext_en(ext_en), .trig_fire(trig_fire), .pin_lvl(pin_lvl), .trig_n(trig_n));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic reset_dut();
      rst_n = 1'b0;
      step(12);
      check(16'(timer_pin_oe), 16'h0000, "oe in reset");
      rst_n = 1'b1;
      step(1);
      check(main_counter, 16'h0000, "counter after reset");
   endtask : reset_dut

   task automatic wr(input logic [1:0] sel, input logic [15:0] d);
      gr_wr_en = 1'b1;
      gr_wr_sel = sel;
      gr_wr_data = d;
      step(1);
      gr_wr_en = 1'b0;
      step(1);
   endtask : wr

   task automatic fire();
      trig_fire = 1'b1;
      step(1);
      trig_fire = 1'b0;
   endtask : fire

   // bounded wait for a counter value
   task automatic wait_cnt(input logic [15:0] v);
      int n;
      n = 0;
      while (main_counter !== v && n < 2000)
      begin
         step(1);
         n++;
      end
      if (n == 2000)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: counter never reached %h", $time, v);
         complete_run();
      end
   endtask : wait_cnt

   // high cycles over two whole periods, independent of window phase
   function automatic int exp_ones(input logic [15:0] a, input logic [15:0] b, input logic init, input logic act);
      if (a == b)
         return (init == act) ? 2 * (a + 1) : 0;
      return act ? 2 * (a - b) : 2 * (b + 1);
   endfunction : exp_ones

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      count_tick = 1'b0;
      gr_wr_en = 1'b0;
      gr_wr_sel = 2'h0;
      gr_wr_data = 16'h0000;
      trig_fire = 1'b0;
      port_out = 4'h0;
      port_oe = 4'h0;
      ext_val = 4'h0;
      ext_en = 4'h1;
      cfg = {1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0};
      for (int c = 0; c < 4; c++)
         ch_cfg[c] = {3'h0, 1'b1, 1'b0, 2'h0};
      reset_dut();
      for (int i = 0; i < 4; i++)
      begin
         port_out = 4'($random(seed));
         port_oe = 4'($random(seed));
         ch_cfg[0].io_ctrl = {1'b0, 2'($random(seed))};
         step(2);
         check(16'({timer_pin_oe, timer_pin_out}), 16'({port_oe, port_out}), "port fallback");
      end
      $display("test port done");
      // init/active table, then two frozen cases with duty equal to period
      for (int k = 0; k < 6; k++)
      begin
         count_tick = 1'b0;
         cfg = {1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1};
         for (int c = 1; c < 4; c++)
            ch_cfg[c] = {3'($random(seed)), 1'b0, 1'b1, k[0], k[1]};
         reset_dut();
         per = 16'(4 + $unsigned($random(seed)) % 12);
         wr(2'h0, per);
         for (int c = 1; c < 4; c++)
         begin
            duty[c] = k[2] ? per : 16'(1 + $unsigned($random(seed)) % (per - 1));
            wr(2'(c), duty[c]);
            check(16'({timer_pin_oe[c], timer_pin_out[c]}), 16'({1'b1, k[0] == k[1]}), "pwm initial");
         end
         count_tick = 1'b1;
         step(int'(per) + 1);
         ones = '{default: 0};
         repeat (2 * (per + 1))
         begin
            for (int c = 1; c < 4; c++)
               ones[c] += timer_pin_out[c];
            step(1);
         end
         for (int c = 1; c < 4; c++)
            check(16'(ones[c]), 16'(exp_ones(per, duty[c], k[0], k[1])), "pwm high count");
      end
      $display("test pwm done");
      count_tick = 1'b0;
      cfg = {1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1};
      ch_cfg[0] = {3'h4, 1'($random(seed)), 1'b0, 2'h0};
      ch_cfg[1] = {3'h0, 1'b1, 1'b0, 2'h0};
      ch_cfg[2] = {3'h2, 1'b0, 1'b0, 2'h0};
      ch_cfg[3] = {3'h1, 1'b0, 1'b0, 2'h0};
      reset_dut();
      wr(2'h0, 16'h0003);
      wr(2'h2, 16'h0005);
      wr(2'h3, 16'h0006);
      count_tick = 1'b1;
      wait_cnt(16'h000a);
      count_tick = 1'b0;
      check(16'({timer_pin_oe[3:2], timer_pin_out[3:2], timer_pin_oe[0]}), 16'h001a, "compare outputs");
      cfg.clear_on_match_a = 1'b1;
      wr(2'h0, 16'hffff);
      ext_val[0] = 1'b1;
      step(6);
      check(main_counter, 16'h0000, "capture clears counter");
      check(general_reg[0], 16'h000a, "captured value");
      $display("test timer done");
      port_oe = 4'hf;
      cfg = {1'b0, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1};
      ch_cfg[1] = {3'($random(seed)), 1'b0, 1'($random(seed)), 1'b0, 1'($random(seed))};
      ch_cfg[2] = {3'h0, 1'b0, 1'b1, 2'h0};
      reset_dut();
      wr(2'h0, 16'h003c);
      wr(2'h1, 16'h0032);
      wr(2'h3, 16'h0014);
      count_tick = 1'b1;
      wait_cnt(16'h0005);
      check(16'({timer_pin_out[2:1], timer_pin_oe[1]}), 16'({port_out[2], 2'b01}), "pulse idle");
      fire();
      step(6);
      check(general_reg[1], 16'h0014, "copy on trigger");
      check(16'(main_counter < 16'h0008), 16'h0001, "trigger restart");
      wait_cnt(16'h0016);
      check(16'(timer_pin_out[1]), 16'h0001, "pulse active");
      wr(2'h3, 16'h0007);
      fire();
      step(8);
      check(general_reg[1], 16'h0014, "ignored trigger copy");
      check(16'(main_counter > 16'h0019), 16'h0001, "ignored trigger restart");
      wait_cnt(16'h0003);
      check(general_reg[1], 16'h0007, "copy on match a");
      check(16'(timer_pin_out[1]), 16'h0000, "pulse back to initial");
      $display("test pulse done");
      count_tick = 1'b0;
      cfg = {1'b1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1};
      reset_dut();
      wr(2'h0, 16'h0004);
      count_tick = 1'b1;
      step(12);
      check(main_counter, 16'h0004, "stop on match a");
      $display("test stop done");
      complete_run();
   end
endmodule : tb
`default_nettype wire

/* File: verif/twoc_ext_model.sv */
// trigger source and pin loads on the far side of the timer output unit
`timescale 1ns/100ps
`default_nettype none
module twoc_ext_model (
   // clock
   input wire logic clk,
   // pins from the unit
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   // bench control
   input wire logic [3:0] ext_val,
   input wire logic [3:0] ext_en,
   input wire logic trig_fire,
   // resolved levels
   output logic [3:0] pin_lvl,
   output logic trig_n
);
   // ----------------------------------------
   // pin wires and trigger line
   // ----------------------------------------
   logic [2:0] low_cnt_ff = 3'h0;
   // undriven pins float high on the pull-up
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
   end
   // low for a few cycles, so the rising edge lands well after the falling one
   always_ff @(posedge clk)
   begin
      if (trig_fire)
         low_cnt_ff <= 3'h5;
      else if (low_cnt_ff != 3'h0)
         low_cnt_ff <= low_cnt_ff - 3'h1;
   end
   assign trig_n = (low_cnt_ff == 3'h0);
endmodule : twoc_ext_model
`default_nettype wire
